/* design/tdmcfg_pkg.sv */
// Package for the timeslot path configuration block: register map,
// message codes, field positions and reset values.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses.
package tdmcfg_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_HOST_STATUS = 8'h00;
    localparam logic [7:0] ADDR_DEV_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_CTRL_HIGH   = 8'h08;
    localparam logic [7:0] ADDR_CTRL_LOW    = 8'h0C;
    localparam logic [7:0] ADDR_MBOX_WR     = 8'h10;
    localparam logic [7:0] ADDR_MBOX_RD     = 8'h14;
    localparam logic [7:0] ADDR_FLAGS       = 8'h18;
    // Message codes in bits 5:0 of the status bytes
    localparam logic [5:0] CODE_SETUP       = 6'h27;
    localparam logic [5:0] CODE_REQUEST     = 6'h07;
    localparam logic [5:0] CODE_RESPONSE    = 6'h27;
    // Path select values in bits 7:6
    localparam logic [1:0] PATH_ONE         = 2'h1;
    localparam logic [1:0] PATH_TWO         = 2'h2;
    localparam logic [7:0] PARAM_COUNT      = 8'h05;
    localparam logic [2:0] PARAM_LAST       = 3'h5;
    // Field positions
    localparam int         CH_ACCESS_BIT    = 7;
    localparam int         CH_COD_LSB       = 1;
    localparam int         CH_RCV_BIT       = 0;
    localparam int         P1_TXD_BIT       = 4;
    localparam int         P1_RXD_BIT       = 3;
    localparam int         FLAG_RSP_BIT     = 0;
    localparam int         FLAG_BAD_BIT     = 1;
    // Masks keeping only defined bits
    localparam logic [7:0] CH_MASK          = 8'h8F;
    localparam logic [7:0] P1_MASK          = 8'h1F;
    localparam logic [7:0] OFS_MASK         = 8'h3F;
    localparam logic [7:0] SHIFT_MASK       = 8'h07;
    // Reset values: byte 0 control high, bytes 1..5 parameters
    localparam logic [5:0][7:0] CFG_RST_ONE = {8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
    localparam logic [5:0][7:0] CFG_RST_TWO = {8'h00, 8'h01, 8'h00, 8'h01, 8'h10, 8'h00};
    // AXI responses
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;
endpackage : tdmcfg_pkg

/* design/tdmcfg_top.sv */
// Timeslot path configuration block: mailbox message interpreter with
// AXI4-Lite register access and per-path highway configuration outputs.
// Assumes one clock, synchronous active-low reset, a well-behaved master.
`timescale 1ns/1ps
`default_nettype none
module tdmcfg_top
    import tdmcfg_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic [2:0]       s_axi_awprot,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic [2:0]       s_axi_arprot,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    output logic [1:0]            highway_access_en,
    output logic [1:0][2:0]       companding_sel,
    output logic [1:0]            rate_conv_en,
    output logic [1:0]            tx_upstream_sel,
    output logic [1:0]            rx_upstream_sel,
    output logic [1:0][2:0]       slot_word_len,
    output logic [1:0][5:0]       rx_slot_offset,
    output logic [1:0][2:0]       rx_bit_shift,
    output logic [1:0][5:0]       tx_slot_offset,
    output logic [1:0][2:0]       tx_bit_shift
);
    import tdmcfg_pkg::*;

    // Bus channel state
    logic                  aw_held_ff, nxt_aw_held;
    logic                  w_held_ff, nxt_w_held;
    logic [7:0]            awaddr_ff, nxt_awaddr;
    logic [31:0]           wdata_ff, nxt_wdata;
    logic                  wstrb0_ff, nxt_wstrb0;
    logic                  bvalid_ff, nxt_bvalid;
    logic [1:0]            bresp_ff, nxt_bresp;
    logic                  rvalid_ff, nxt_rvalid;
    logic [31:0]           rdata_ff, nxt_rdata;
    logic [1:0]            rresp_ff, nxt_rresp;
    // Mailbox and message state
    logic [7:0]            dev_status_ff, nxt_dev_status;
    logic [7:0]            ctrl_high_ff, nxt_ctrl_high;
    logic [7:0]            ctrl_low_ff, nxt_ctrl_low;
    logic [4:0][7:0]       mbox_in_ff, nxt_mbox_in;
    logic [2:0]            wr_idx_ff, nxt_wr_idx;
    logic [4:0][7:0]       rsp_ff, nxt_rsp;
    logic [2:0]            rd_idx_ff, nxt_rd_idx;
    logic                  rsp_flag_ff, nxt_rsp_flag;
    logic                  bad_flag_ff, nxt_bad_flag;
    // Per-path configuration: byte 0 control high, 1..5 parameters
    logic [5:0][7:0]       cfg_ff [2];

    logic                  do_wr;
    logic                  do_rd;
    logic                  msg_go;
    logic [1:0]            msg_path;
    logic                  path_ok;
    logic                  path_idx;
    logic                  setup_ok;
    logic                  request_ok;
    logic                  wr_mapped;
    logic                  rd_mapped;

    assign do_wr      = aw_held_ff && w_held_ff && !bvalid_ff;
    assign do_rd      = s_axi_arvalid && !rvalid_ff;
    assign msg_go     = do_wr && wstrb0_ff && (awaddr_ff == ADDR_HOST_STATUS);
    assign msg_path   = wdata_ff[7:6];
    assign path_ok    = (msg_path == PATH_ONE) || (msg_path == PATH_TWO);
    assign path_idx   = (msg_path == PATH_TWO);
    assign setup_ok   = msg_go && path_ok && (wdata_ff[5:0] == CODE_SETUP)
                        && (ctrl_low_ff == PARAM_COUNT) && (wr_idx_ff == PARAM_LAST);
    assign request_ok = msg_go && path_ok && (wdata_ff[5:0] == CODE_REQUEST);
    assign wr_mapped  = (awaddr_ff == ADDR_HOST_STATUS) || (awaddr_ff == ADDR_CTRL_HIGH)
                        || (awaddr_ff == ADDR_CTRL_LOW) || (awaddr_ff == ADDR_MBOX_WR)
                        || (awaddr_ff == ADDR_FLAGS) || (awaddr_ff == ADDR_DEV_STATUS)
                        || (awaddr_ff == ADDR_MBOX_RD);
    assign rd_mapped  = (s_axi_araddr <= ADDR_FLAGS) && (s_axi_araddr[1:0] == 2'h0);

    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready  = !w_held_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // Bus and message next state
    always_comb
    begin
        nxt_aw_held    = aw_held_ff;
        nxt_w_held     = w_held_ff;
        nxt_awaddr     = awaddr_ff;
        nxt_wdata      = wdata_ff;
        nxt_wstrb0     = wstrb0_ff;
        nxt_bvalid     = bvalid_ff;
        nxt_bresp      = bresp_ff;
        nxt_rvalid     = rvalid_ff && !s_axi_rready;
        nxt_rdata      = rdata_ff;
        nxt_rresp      = rresp_ff;
        nxt_dev_status = dev_status_ff;
        nxt_ctrl_high  = ctrl_high_ff;
        nxt_ctrl_low   = ctrl_low_ff;
        nxt_mbox_in    = mbox_in_ff;
        nxt_wr_idx     = wr_idx_ff;
        nxt_rsp        = rsp_ff;
        nxt_rd_idx     = rd_idx_ff;
        nxt_rsp_flag   = rsp_flag_ff;
        nxt_bad_flag   = bad_flag_ff;
        if (s_axi_awvalid && !aw_held_ff)
        begin
            nxt_aw_held = 1'b1;
            nxt_awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_ff)
        begin
            nxt_w_held = 1'b1;
            nxt_wdata  = s_axi_wdata;
            nxt_wstrb0 = s_axi_wstrb[0];
        end
        if (bvalid_ff && s_axi_bready)
        begin
            nxt_bvalid  = 1'b0;
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
        end
        if (do_wr)
        begin
            nxt_bvalid = 1'b1;
            nxt_bresp  = wr_mapped ? RESP_OKAY : RESP_SLVERR;
            if (wstrb0_ff)
            begin
                case (awaddr_ff)
                    ADDR_CTRL_HIGH: nxt_ctrl_high = wdata_ff[7:0];
                    ADDR_CTRL_LOW:  nxt_ctrl_low  = wdata_ff[7:0];
                    ADDR_MBOX_WR:
                        if (wr_idx_ff < PARAM_LAST)
                        begin
                            nxt_mbox_in[wr_idx_ff] = wdata_ff[7:0];
                            nxt_wr_idx             = wr_idx_ff + 3'h1;
                        end
                    ADDR_FLAGS:
                    begin
                        nxt_rsp_flag = rsp_flag_ff && !wdata_ff[FLAG_RSP_BIT];
                        nxt_bad_flag = bad_flag_ff && !wdata_ff[FLAG_BAD_BIT];
                    end
                    default: nxt_wr_idx = wr_idx_ff;
                endcase
            end
        end
        if (msg_go)
        begin
            nxt_wr_idx = 3'h0;
            if (request_ok)
            begin
                nxt_dev_status = {msg_path, CODE_RESPONSE};
                nxt_ctrl_high  = cfg_ff[path_idx][0];
                nxt_ctrl_low   = PARAM_COUNT;
                nxt_rsp        = cfg_ff[path_idx][5:1];
                nxt_rd_idx     = 3'h0;
                nxt_rsp_flag   = 1'b1;
            end
            else if (!setup_ok)
            begin
                nxt_bad_flag = 1'b1;
            end
        end
        if (do_rd)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = rd_mapped ? RESP_OKAY : RESP_SLVERR;
            nxt_rdata  = 32'h0000_0000;
            case (s_axi_araddr)
                ADDR_DEV_STATUS: nxt_rdata[7:0] = dev_status_ff;
                ADDR_CTRL_HIGH:  nxt_rdata[7:0] = ctrl_high_ff;
                ADDR_CTRL_LOW:   nxt_rdata[7:0] = ctrl_low_ff;
                ADDR_MBOX_RD:
                    if (rd_idx_ff < PARAM_LAST)
                    begin
                        nxt_rdata[7:0] = rsp_ff[rd_idx_ff];
                        nxt_rd_idx     = rd_idx_ff + 3'h1;
                    end
                ADDR_FLAGS:
                begin
                    nxt_rdata[FLAG_RSP_BIT] = rsp_flag_ff;
                    nxt_rdata[FLAG_BAD_BIT] = bad_flag_ff;
                    nxt_rdata[10:8]         = wr_idx_ff;
                end
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            awaddr_ff     <= 8'h00;
            wdata_ff      <= 32'h0000_0000;
            wstrb0_ff     <= 1'b0;
            bvalid_ff     <= 1'b0;
            bresp_ff      <= RESP_OKAY;
            rvalid_ff     <= 1'b0;
            rdata_ff      <= 32'h0000_0000;
            rresp_ff      <= RESP_OKAY;
            dev_status_ff <= 8'h00;
            ctrl_high_ff  <= 8'h00;
            ctrl_low_ff   <= 8'h00;
            mbox_in_ff    <= '0;
            wr_idx_ff     <= 3'h0;
            rsp_ff        <= '0;
            rd_idx_ff     <= 3'h0;
            rsp_flag_ff   <= 1'b0;
            bad_flag_ff   <= 1'b0;
        end
        else
        begin
            aw_held_ff    <= nxt_aw_held;
            w_held_ff     <= nxt_w_held;
            awaddr_ff     <= nxt_awaddr;
            wdata_ff      <= nxt_wdata;
            wstrb0_ff     <= nxt_wstrb0;
            bvalid_ff     <= nxt_bvalid;
            bresp_ff      <= nxt_bresp;
            rvalid_ff     <= nxt_rvalid;
            rdata_ff      <= nxt_rdata;
            rresp_ff      <= nxt_rresp;
            dev_status_ff <= nxt_dev_status;
            ctrl_high_ff  <= nxt_ctrl_high;
            ctrl_low_ff   <= nxt_ctrl_low;
            mbox_in_ff    <= nxt_mbox_in;
            wr_idx_ff     <= nxt_wr_idx;
            rsp_ff        <= nxt_rsp;
            rd_idx_ff     <= nxt_rd_idx;
            rsp_flag_ff   <= nxt_rsp_flag;
            bad_flag_ff   <= nxt_bad_flag;
        end
    end

    // Per-path configuration store and outputs
    for (genvar p = 0; p < 2; p++)
    begin : g_path
        logic [5:0][7:0] nxt_cfg;

        always_comb
        begin
            nxt_cfg = cfg_ff[p];
            if (setup_ok && (path_idx == 1'(p)))
            begin
                nxt_cfg[0] = ctrl_high_ff  & CH_MASK;
                nxt_cfg[1] = mbox_in_ff[0] & P1_MASK;
                nxt_cfg[2] = mbox_in_ff[1] & OFS_MASK;
                nxt_cfg[3] = mbox_in_ff[2] & SHIFT_MASK;
                nxt_cfg[4] = mbox_in_ff[3] & OFS_MASK;
                nxt_cfg[5] = mbox_in_ff[4] & SHIFT_MASK;
            end
        end

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                cfg_ff[p] <= (p == 0) ? CFG_RST_ONE : CFG_RST_TWO;
            end
            else
            begin
                cfg_ff[p] <= nxt_cfg;
            end
        end

        assign highway_access_en[p] = cfg_ff[p][0][CH_ACCESS_BIT];
        assign companding_sel[p]    = cfg_ff[p][0][CH_COD_LSB +: 3];
        assign rate_conv_en[p]      = cfg_ff[p][0][CH_RCV_BIT];
        assign tx_upstream_sel[p]   = cfg_ff[p][1][P1_TXD_BIT];
        assign rx_upstream_sel[p]   = cfg_ff[p][1][P1_RXD_BIT];
        assign slot_word_len[p]     = cfg_ff[p][1][2:0];
        assign rx_slot_offset[p]    = cfg_ff[p][2][5:0];
        assign rx_bit_shift[p]      = cfg_ff[p][3][2:0];
        assign tx_slot_offset[p]    = cfg_ff[p][4][5:0];
        assign tx_bit_shift[p]      = cfg_ff[p][5][2:0];
    end
endmodule : tdmcfg_top
`default_nettype wire

/* tb/tdmcfg_sva.sv */
// Checker: bus timing and per-path configuration assertions on the top ports.
// Assumes one clock and the synchronous active-low reset; bound from the bench.
`timescale 1ns/1ps
`default_nettype none
module tdmcfg_sva (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic [1:0]       highway_access_en,
    input wire logic [1:0][2:0]  companding_sel,
    input wire logic [1:0]       rate_conv_en,
    input wire logic [1:0]       tx_upstream_sel,
    input wire logic [1:0]       rx_upstream_sel,
    input wire logic [1:0][2:0]  slot_word_len,
    input wire logic [1:0][5:0]  rx_slot_offset,
    input wire logic [1:0][2:0]  rx_bit_shift,
    input wire logic [1:0][5:0]  tx_slot_offset,
    input wire logic [1:0][2:0]  tx_bit_shift
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic [27:0] cfg0 = {highway_access_en[0], companding_sel[0], rate_conv_en[0], tx_upstream_sel[0],
        rx_upstream_sel[0], slot_word_len[0], rx_slot_offset[0], rx_bit_shift[0], tx_slot_offset[0], tx_bit_shift[0]};
    wire logic [27:0] cfg1 = {highway_access_en[1], companding_sel[1], rate_conv_en[1], tx_upstream_sel[1],
        rx_upstream_sel[1], slot_word_len[1], rx_slot_offset[1], rx_bit_shift[1], tx_slot_offset[1], tx_bit_shift[1]};
    a_reset_lines: assert property ($rose(aresetn) |-> tx_upstream_sel == 2'h3 && rx_upstream_sel == 2'h0)
        else $error("line selects wrong after reset");
    a_reset_offsets: assert property ($rose(aresetn) |-> rx_slot_offset == 12'h040 && tx_slot_offset == 12'h040)
        else $error("slot offsets wrong after reset");
    a_reset_length: assert property ($rose(aresetn) |-> {slot_word_len, rx_bit_shift, tx_bit_shift} == 18'h00000)
        else $error("length or shifts wrong after reset");
    a_one_path: assert property ($changed(cfg0) |-> $stable(cfg1))
        else $error("both paths changed by one message");
    a_change_on_msg: assert property ($changed({cfg0, cfg1}) |-> $rose(s_axi_bvalid))
        else $error("configuration changed outside a message write");
    a_unused_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:11] == 21'h000000)
        else $error("unused read bits not zero");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response not two edges after take");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one edge after take");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
endmodule : tdmcfg_sva
`default_nettype wire

/* tb/tdmcfg_host.sv */
// Host model: AXI4-Lite master sending setup and request messages.
// Assumes the slave answers; the bench timeout ends any hang.
`timescale 1ns/1ps
`default_nettype none
module tdmcfg_host
    import tdmcfg_pkg::*;
(
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid  <= s_axi_wvalid && !s_axi_wready;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        s_axi_awaddr <= ~a;
        s_axi_wdata  <= ~s_axi_wdata;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        s_axi_araddr <= ~a;
    endtask : rd
    task automatic setup(input logic [1:0] p, input logic [7:0] ch, input logic [4:0][7:0] prm, input int n,
                         output logic [1:0] r);
        for (int i = 0; i < n; i++)
            wr(ADDR_MBOX_WR, prm[i], r);
        wr(ADDR_CTRL_HIGH, ch, r);
        wr(ADDR_CTRL_LOW, PARAM_COUNT, r);
        wr(ADDR_HOST_STATUS, {p, CODE_SETUP}, r);
    endtask : setup
    task automatic request(input logic [1:0] p, output logic [1:0] r);
        wr(ADDR_CTRL_HIGH, 8'h00, r);
        wr(ADDR_CTRL_LOW, 8'h00, r);
        wr(ADDR_HOST_STATUS, {p, CODE_REQUEST}, r);
    endtask : request
endmodule : tdmcfg_host
`default_nettype wire

/* tb/tdmcfg_top_tb.sv */
// Bench: mailbox messages over AXI4-Lite, checks path outputs and responses.
// Assumes the host model for bus cycles and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tdmcfg_top_tb;
    import tdmcfg_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, highway_access_en, rate_conv_en, tx_upstream_sel, rx_upstream_sel, r;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, ch;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0][2:0] companding_sel, slot_word_len, rx_bit_shift, tx_bit_shift;
    logic [1:0][5:0] rx_slot_offset, tx_slot_offset;
    logic [4:0][7:0] prm;
    localparam logic [4:0][7:0] RST_ONE = 40'h0000000010;
    localparam logic [4:0][7:0] RST_TWO = 40'h0001000110;
    localparam logic [4:0][7:0] JUNK    = 40'hF8C0F8C0E0;
    logic [7:0]  regs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18};
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cycles = 0;
    tdmcfg_top  u_dut (.*);
    tdmcfg_host u_host (.*);
    initial aclk = 1'b0;
    always #4 aclk = ~aclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        if (n_mismatch == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    function automatic logic [27:0] pack(input logic [7:0] c, input logic [4:0][7:0] p);
        return {c[7], c[3:1], c[0], p[0][4], p[0][3], p[0][2:0], p[1][5:0], p[2][2:0], p[3][5:0], p[4][2:0]};
    endfunction : pack
    function automatic logic [27:0] cfg(input int i);
        return {highway_access_en[i], companding_sel[i], rate_conv_en[i], tx_upstream_sel[i], rx_upstream_sel[i],
                slot_word_len[i], rx_slot_offset[i], rx_bit_shift[i], tx_slot_offset[i], tx_bit_shift[i]};
    endfunction : cfg
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check(cfg(0), pack(8'h00, RST_ONE));
        check(cfg(1), pack(8'h00, RST_TWO));
    endtask : do_reset
    task automatic expect_resp(input logic [1:0] p, input logic [7:0] c, input logic [4:0][7:0] v);
        u_host.wr(ADDR_FLAGS, 8'h03, r);
        u_host.request(p, r);
        check(r, RESP_OKAY);
        u_host.rd(ADDR_DEV_STATUS, d, r);
        check(d, {24'h000000, p, CODE_RESPONSE});
        check(r, RESP_OKAY);
        u_host.rd(ADDR_CTRL_HIGH, d, r);
        check(d, {24'h000000, c});
        u_host.rd(ADDR_CTRL_LOW, d, r);
        check(d, 32'h00000005);
        u_host.rd(ADDR_FLAGS, d, r);
        check(d, 32'h00000001);
        for (int k = 0; k < 6; k++)
        begin
            u_host.rd(ADDR_MBOX_RD, d, r);
            check(d, k < 5 ? {24'h000000, v[k]} : 32'h00000000);
        end
    endtask : expect_resp
    initial
    begin
        aresetn = 1'b0;
        s_axi_awprot = 3'h0;
        s_axi_arprot = 3'h0;
        s_axi_wstrb = 4'hF;
        do_reset();
        foreach (regs[k])
        begin
            u_host.rd(regs[k], d, r);
            check(d, 32'h00000000);
        end
        u_host.wr(8'h1C, 8'h5A, r);
        check(r, RESP_SLVERR);
        u_host.rd(8'h1C, d, r);
        check({d[31:2], r}, {30'h00000000, RESP_SLVERR});
        s_axi_wstrb <= 4'hE;
        u_host.wr(ADDR_CTRL_LOW, PARAM_COUNT, r);
        check(r, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        u_host.rd(ADDR_CTRL_LOW, d, r);
        check(d, 32'h00000000);
        for (int c = 0; c < 3; c++)
        begin
            ch = {c != 0, 3'h0, 3'(c), c != 0};
            prm = {5'h00, 3'(7 - c), 2'h0, 6'(21 * c), 5'h00, 3'(7 - c), 2'h0, 6'(63 - c), 3'h0, c[0], ~c[0], 3'(c + 1)};
            u_host.setup(PATH_TWO, ch | (c == 1 ? 8'h70 : 8'h00), prm | (c == 1 ? JUNK : 40'h0), 5, r);
            check(cfg(1), pack(ch, prm));
            check(cfg(0), pack(8'h00, RST_ONE));
            expect_resp(PATH_TWO, ch, prm);
        end
        for (int b = 0; b < 2; b++)
        begin
            u_host.wr(ADDR_FLAGS, 8'h03, r);
            u_host.setup(b ? PATH_ONE : 2'h0, 8'h83, prm, 5 - b, r);
            u_host.rd(ADDR_FLAGS, d, r);
            check(d, 32'h00000002);
            check(cfg(0), pack(8'h00, RST_ONE));
            check(cfg(1), pack(ch, prm));
        end
        do_reset();
        expect_resp(PATH_ONE, 8'h00, RST_ONE);
        u_host.setup(PATH_ONE, ch, prm, 5, r);
        check(cfg(0), pack(ch, prm));
        check(cfg(1), pack(8'h00, RST_TWO));
        stop_test();
    end
endmodule : tdmcfg_top_tb
bind tdmcfg_top tdmcfg_sva u_sva (.*);
`default_nettype wire
